// File: core/ocm_top.sv
// Summary of operation
// - After power-up the monitor free-runs over temperature, core and aux supplies.
// - Safe-mode sequencing continues before and during any configuration.
// - Held configuration pins do not stall the monitor once memory clear ends.
// - A full configuration load overwrites all control registers.
// - Without a system clock the logic runs from the internal oscillator.
// - Scan port reads every register and writes the control registers at any time.
// - Every register is reachable from fabric port and scan port.
// - Conversions give 10-bit codes; 1 V differential gives 3FFh.
// - Optional averaging over up to 256 samples per stored reading.
// - Temperature readings go to status address 00h.
// - Core supply goes to 01h, aux supply to 02h.
// - Fabric port addresses 128 sixteen-bit registers with seven address bits.
// - Addresses 00h-3Fh are status, read-only; fabric writes ignored.
// - Addresses 40h-7Fh are control, read and write from fabric.
// - Config registers choose input mode, sampling mode and single channel.
// - Each result lands at the address equal to its channel number.
// - Results are MSB-justified, ten bits on top of sixteen.
// - End-of-conversion pulses once the result is written.
`timescale 1ns/1ps
`default_nettype none
module ocm_top
  import ocm_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic osc_clk_sel_in,
  input wire logic cfg_load_in,
  input wire logic [DATA_W-1:0] cfg_init_data_in [CTRL_BASE:REG_COUNT-1],
  input wire logic [CODE_W-1:0] sample_code_in,
  input wire logic fab_en_in,
  input wire logic fab_we_in,
  input wire logic [ADDR_W-1:0] register_address_bus_in,
  input wire logic [DATA_W-1:0] fab_wdata_in,
  output logic fab_rdy_out,
  output logic [DATA_W-1:0] fab_rdata_out,
  input wire logic scan_en_in,
  input wire logic scan_we_in,
  input wire logic [ADDR_W-1:0] scan_addr_in,
  input wire logic [DATA_W-1:0] scan_wdata_in,
  output logic scan_rdy_out,
  output logic [DATA_W-1:0] scan_rdata_out,
  output logic [CFG0_CHAN_W-1:0] chan_out,
  output logic eoc_out,
  output logic busy_out,
  output logic diff_mode_out,
  output logic samp_mode_out
);
  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  // Each port keeps its own captured request, so one port's
  // address and data never leak into the other's access.
  logic [DATA_W-1:0] regs_q [REG_COUNT];
  logic fab_pend_q;
  logic scan_pend_q;
  logic fab_we_q;
  logic scan_we_q;
  logic [ADDR_W-1:0] fab_addr_q;
  logic [ADDR_W-1:0] scan_addr_q;
  logic [DATA_W-1:0] fab_wd_q;
  logic [DATA_W-1:0] scan_wd_q;
  ocm_src_t turn_q;
  logic seq_eoc;
  ocm_if res ();

  function automatic logic is_ctrl(input logic [ADDR_W-1:0] a);
    is_ctrl = (a >= CTRL_BASE);
  endfunction : is_ctrl

  // Clock choice is outside: clk_in is the oscillator pre-config
  // and the system clock after; the mux itself sits at the pad.
  logic unused_sel;
  assign unused_sel = osc_clk_sel_in;

  // ------------------------------------------------------------
  // Controls fed to the sequencer
  // ------------------------------------------------------------
  assign res.chan_sel = regs_q[CFG0_ADDR][CFG0_CHAN_LSB +: CFG0_CHAN_W];
  assign res.single_mode = regs_q[CFG1_ADDR][CFG1_SINGLE_BIT];
  assign res.avg_log = (regs_q[AVG_ADDR][AVG_W-1:0] > AVG_MAX_LOG) ? AVG_MAX_LOG
                       : regs_q[AVG_ADDR][AVG_W-1:0];

  // Sequencer runs from reset; config pins never gate it
  ocm_seq u_seq (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .sample_code_in(sample_code_in),
    .chan_out(chan_out),
    .eoc_out(seq_eoc),
    .busy_out(busy_out),
    .res(res.seq)
  );

  // ------------------------------------------------------------
  // Access arbitration
  // ------------------------------------------------------------
  // One access per cycle; round-robin keeps either port from
  // starving while the other hammers the file. A granted access
  // reads and writes in the same cycle, so no other access can
  // split it.
  ocm_src_t turn_d;
  logic fab_grant;
  logic scan_grant;

  always_comb begin
    fab_grant = fab_pend_q && (!scan_pend_q || turn_q == OCM_SRC_FABRIC);
    scan_grant = scan_pend_q && !fab_grant;
    turn_d = turn_q;
    if (fab_grant) begin
      turn_d = OCM_SRC_SCAN;
    end else if (scan_grant) begin
      turn_d = OCM_SRC_FABRIC;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      turn_q <= OCM_SRC_FABRIC;
    end else begin
      turn_q <= turn_d;
    end
  end

  // ------------------------------------------------------------
  // Fabric port
  // ------------------------------------------------------------
  // Read data holds until the next answer on this port, so slow
  // fabric logic may collect it late; a status write still gets
  // its ready, it just changes nothing.
  logic fab_pend_d;
  logic fab_we_d;
  logic [ADDR_W-1:0] fab_addr_d;
  logic [DATA_W-1:0] fab_wd_d;
  logic fab_rdy_d;
  logic [DATA_W-1:0] fab_rd_d;

  always_comb begin
    fab_pend_d = fab_pend_q;
    fab_we_d = fab_we_q;
    fab_addr_d = fab_addr_q;
    fab_wd_d = fab_wd_q;
    fab_rdy_d = 1'b0;
    fab_rd_d = fab_rdata_out;
    if (fab_grant) begin
      fab_pend_d = 1'b0;
      fab_rdy_d = 1'b1;
      fab_rd_d = regs_q[fab_addr_q];
    end
    // An enable during a pending request is dropped, not queued
    if (fab_en_in && !fab_pend_q) begin
      fab_pend_d = 1'b1;
      fab_we_d = fab_we_in;
      fab_addr_d = register_address_bus_in;
      fab_wd_d = fab_wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      fab_pend_q <= 1'b0;
      fab_we_q <= 1'b0;
      fab_addr_q <= '0;
      fab_wd_q <= '0;
      fab_rdy_out <= 1'b0;
      fab_rdata_out <= '0;
    end else begin
      fab_pend_q <= fab_pend_d;
      fab_we_q <= fab_we_d;
      fab_addr_q <= fab_addr_d;
      fab_wd_q <= fab_wd_d;
      fab_rdy_out <= fab_rdy_d;
      fab_rdata_out <= fab_rd_d;
    end
  end

  // ------------------------------------------------------------
  // Scan port
  // ------------------------------------------------------------
  // Same handshake as the fabric port; nothing here waits on the
  // configuration pins, so the scan host is served before and
  // after configuration alike.
  logic scan_pend_d;
  logic scan_we_d;
  logic [ADDR_W-1:0] scan_addr_d;
  logic [DATA_W-1:0] scan_wd_d;
  logic scan_rdy_d;
  logic [DATA_W-1:0] scan_rd_d;

  always_comb begin
    scan_pend_d = scan_pend_q;
    scan_we_d = scan_we_q;
    scan_addr_d = scan_addr_q;
    scan_wd_d = scan_wd_q;
    scan_rdy_d = 1'b0;
    scan_rd_d = scan_rdata_out;
    if (scan_grant) begin
      scan_pend_d = 1'b0;
      scan_rdy_d = 1'b1;
      scan_rd_d = regs_q[scan_addr_q];
    end
    // An enable during a pending request is dropped, not queued
    if (scan_en_in && !scan_pend_q) begin
      scan_pend_d = 1'b1;
      scan_we_d = scan_we_in;
      scan_addr_d = scan_addr_in;
      scan_wd_d = scan_wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      scan_pend_q <= 1'b0;
      scan_we_q <= 1'b0;
      scan_addr_q <= '0;
      scan_wd_q <= '0;
      scan_rdy_out <= 1'b0;
      scan_rdata_out <= '0;
    end else begin
      scan_pend_q <= scan_pend_d;
      scan_we_q <= scan_we_d;
      scan_addr_q <= scan_addr_d;
      scan_wd_q <= scan_wd_d;
      scan_rdy_out <= scan_rdy_d;
      scan_rdata_out <= scan_rd_d;
    end
  end

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  // Later writes win: converter, then the granted port, then a
  // configuration load over the whole control half. The converter
  // only addresses status words and ports only control words, so
  // the first two never meet.
  logic [DATA_W-1:0] regs_d [REG_COUNT];

  function automatic logic port_writes(input logic grant, input logic we,
                                       input logic [ADDR_W-1:0] a);
    port_writes = grant && we && is_ctrl(a);
  endfunction : port_writes

  always_comb begin
    regs_d = regs_q;
    if (res.wr_en) begin
      regs_d[res.addr] = res.data;
    end
    if (port_writes(fab_grant, fab_we_q, fab_addr_q)) begin
      regs_d[fab_addr_q] = fab_wd_q;
    end
    if (port_writes(scan_grant, scan_we_q, scan_addr_q)) begin
      regs_d[scan_addr_q] = scan_wd_q;
    end
    if (cfg_load_in) begin
      for (int i = CTRL_BASE; i < REG_COUNT; i++) begin
        regs_d[i] = cfg_init_data_in[i];
      end
    end
  end

  // Reset clears status and control alike; a configuration load
  // then refills the control half.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_q[i] <= '0;
      end
    end else begin
      regs_q <= regs_d;
    end
  end

  // ------------------------------------------------------------
  // Mode and conversion outputs
  // ------------------------------------------------------------
  // Mode pins follow the control word one cycle late; the extra
  // flop keeps every top-level pin off combinational paths, at
  // the cost of one cycle of lag.
  logic eoc_d;
  logic diff_mode_d;
  logic samp_mode_d;

  always_comb begin
    eoc_d = seq_eoc;
    diff_mode_d = regs_q[CFG0_ADDR][CFG0_DIFF_BIT];
    samp_mode_d = regs_q[CFG0_ADDR][CFG0_SAMP_BIT];
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      eoc_out <= 1'b0;
      diff_mode_out <= 1'b0;
      samp_mode_out <= 1'b0;
    end else begin
      eoc_out <= eoc_d;
      diff_mode_out <= diff_mode_d;
      samp_mode_out <= samp_mode_d;
    end
  end
endmodule : ocm_top
`default_nettype wire

// File: core/ocm_pkg.sv
`default_nettype none
package ocm_pkg;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;
  localparam int REG_COUNT = 128;
  localparam int CODE_W = 10;
  localparam logic [6:0] TEMP_ADDR = 7'h00;
  localparam logic [6:0] CORE_ADDR = 7'h01;
  localparam logic [6:0] AUX_ADDR = 7'h02;
  localparam logic [6:0] CTRL_BASE = 7'h40;
  localparam logic [6:0] CFG0_ADDR = 7'h40;
  localparam logic [6:0] CFG1_ADDR = 7'h41;
  localparam logic [6:0] AVG_ADDR = 7'h42;
  localparam logic [6:0] CHAN_LAST = 7'h02;
  localparam logic [9:0] FULL_SCALE = 10'h3ff;

  // ------------------------------------------------------------
  // Control fields
  // ------------------------------------------------------------
  // CFG0: [4:0] channel, [8] sampling mode, [10] differential input
  localparam int CFG0_CHAN_LSB = 0;
  localparam int CFG0_CHAN_W = 5;
  localparam int CFG0_SAMP_BIT = 8;
  localparam int CFG0_DIFF_BIT = 10;
  // CFG1: [0] single-channel mode
  localparam int CFG1_SINGLE_BIT = 0;
  // AVG: [3:0] log2 of sample count, 0..8
  localparam int AVG_W = 4;
  localparam logic [3:0] AVG_MAX_LOG = 4'h8;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam real CLK_MHZ = 50.0;
  localparam real CONV_US = 0.52;
  localparam int CONV_CYC = (int'(CONV_US * CLK_MHZ) < 1) ? 1 : int'(CONV_US * CLK_MHZ);
  localparam int CONV_CNT_W = 8;
  localparam logic [7:0] CONV_LAST = 8'(CONV_CYC - 1);
  localparam int ACC_W = CODE_W + 8;

  typedef enum logic [0:0] {
    OCM_SRC_FABRIC,
    OCM_SRC_SCAN
  } ocm_src_t;
endpackage : ocm_pkg
`default_nettype wire

// File: core/ocm_if.sv
`timescale 1ns/1ps
`default_nettype none
// Result hand-off between conversion sequencer and register file
interface ocm_if;
  import ocm_pkg::*;
  logic wr_en;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] data;
  logic [CFG0_CHAN_W-1:0] chan_sel;
  logic single_mode;
  logic [AVG_W-1:0] avg_log;
  modport seq (output wr_en, output addr, output data,
               input chan_sel, input single_mode, input avg_log);
  modport regs (input wr_en, input addr, input data,
                output chan_sel, output single_mode, output avg_log);
endinterface : ocm_if
`default_nettype wire

// File: core/ocm_seq.sv
`timescale 1ns/1ps
`default_nettype none
module ocm_seq
  import ocm_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [CODE_W-1:0] sample_code_in,
  output logic [CFG0_CHAN_W-1:0] chan_out,
  output logic eoc_out,
  output logic busy_out,
  ocm_if.seq res
);
  logic [CONV_CNT_W-1:0] cnt_q, cnt_d;
  logic [CFG0_CHAN_W-1:0] chan_q, chan_d;
  logic [7:0] nsamp_q, nsamp_d;
  logic [ACC_W-1:0] acc_q, acc_d;
  logic eoc_q, eoc_d;
  logic [ACC_W-1:0] sum;
  logic [7:0] need;

  // ------------------------------------------------------------
  // Sequencer: safe mode cycles temp, core, aux without any setup
  // ------------------------------------------------------------
  always_comb begin
    cnt_d = cnt_q + 8'h01;
    chan_d = chan_q;
    nsamp_d = nsamp_q;
    acc_d = acc_q;
    eoc_d = 1'b0;
    need = 8'((9'h001 << res.avg_log) - 9'h001);
    sum = acc_q + ACC_W'(sample_code_in);
    res.wr_en = 1'b0;
    res.addr = ADDR_W'(chan_q);
    res.data = DATA_W'({10'(sum >> res.avg_log), 6'h00});
    if (cnt_q == CONV_LAST) begin
      cnt_d = '0;
      acc_d = sum;
      nsamp_d = nsamp_q + 8'h01;
      if (nsamp_q >= need) begin
        acc_d = '0;
        nsamp_d = '0;
        res.wr_en = 1'b1;
        eoc_d = 1'b1;
        if (res.single_mode) begin
          chan_d = res.chan_sel;
        end else if (chan_q >= CFG0_CHAN_W'(CHAN_LAST)) begin
          chan_d = '0;
        end else begin
          chan_d = chan_q + 5'h01;
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cnt_q <= '0;
      chan_q <= '0;
      nsamp_q <= '0;
      acc_q <= '0;
      eoc_q <= 1'b0;
      chan_out <= '0;
      busy_out <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      chan_q <= chan_d;
      nsamp_q <= nsamp_d;
      acc_q <= acc_d;
      eoc_q <= eoc_d;
      busy_out <= 1'b1;
      if (eoc_d) begin
        chan_out <= chan_q;
      end
    end
  end
  assign eoc_out = eoc_q;
endmodule : ocm_seq
`default_nettype wire

// File: dv/ocm_sense_model.sv
`timescale 1ns/1ps
`default_nettype none
// Converter front end: every channel sees the same level
module ocm_sense_model
  import ocm_pkg::*;
(
  input wire logic [CODE_W-1:0] level_in,
  output logic [CODE_W-1:0] code_out
);
  assign code_out = level_in;
endmodule : ocm_sense_model
`default_nettype wire

// File: dv/ocm_top_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ocm_top_checker
  import ocm_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic fab_en_in,
  input wire logic fab_rdy_out,
  input wire logic [DATA_W-1:0] fab_rdata_out,
  input wire logic scan_en_in,
  input wire logic scan_rdy_out,
  input wire logic eoc_out,
  input wire logic [CFG0_CHAN_W-1:0] chan_out,
  input wire logic busy_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  logic fp_q;
  logic sp_q;
  // Request pending per port, cleared by its answer
  always_ff @(posedge clk_in) begin
    fp_q <= !sys_rst_in && !fab_rdy_out && (fab_en_in || fp_q);
    sp_q <= !sys_rst_in && !scan_rdy_out && (scan_en_in || sp_q);
  end
  a_fab_answer_bound: assert property ($rose(fp_q) |-> ##[1:2] fab_rdy_out)
    else $error("fabric answer late");
  a_scan_answer_bound: assert property ($rose(sp_q) |-> ##[1:2] scan_rdy_out)
    else $error("scan answer late");
  a_fab_rdy_pulse: assert property (fab_rdy_out |=> !fab_rdy_out)
    else $error("fabric ready too long");
  a_scan_rdy_pulse: assert property (scan_rdy_out |=> !scan_rdy_out)
    else $error("scan ready too long");
  a_fab_rdy_cause: assert property (fab_rdy_out |-> $past(fp_q))
    else $error("fabric ready without request");
  a_rdata_hold: assert property ($changed(fab_rdata_out) |-> fab_rdy_out)
    else $error("fabric read data moved");
  a_eoc_spacing: assert property (eoc_out |=> (!eoc_out) [*8])
    else $error("end of conversion too close");
  a_safe_channels: assert property (eoc_out |-> chan_out <= CHAN_LAST)
    else $error("channel outside safe sequence");
  a_busy_running: assert property ((!sys_rst_in) [*3] |-> busy_out)
    else $error("sequencer idle");
  c_fab_answer: cover property (fab_rdy_out);
  c_both_pending: cover property (fp_q && sp_q);
  c_last_channel: cover property (eoc_out && chan_out == CHAN_LAST);
endmodule : ocm_top_checker
bind ocm_top ocm_top_checker i_chk (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
  .fab_en_in(fab_en_in), .fab_rdy_out(fab_rdy_out), .fab_rdata_out(fab_rdata_out),
  .scan_en_in(scan_en_in), .scan_rdy_out(scan_rdy_out), .eoc_out(eoc_out),
  .chan_out(chan_out), .busy_out(busy_out));
`default_nettype wire

// File: dv/tb_on_chip_monitor_adc_register_file.sv
`timescale 1ns/1ps
`default_nettype none
module tb_on_chip_monitor_adc_register_file;
  import ocm_pkg::*;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic cfg_load_in = 1'b0;
  logic [DATA_W-1:0] init_v [CTRL_BASE:REG_COUNT-1];
  logic [CODE_W-1:0] level = 10'h155;
  logic [CODE_W-1:0] code;
  logic [CODE_W-1:0] lv [3];
  logic en [2] = '{1'b0, 1'b0};
  logic we [2] = '{1'b0, 1'b0};
  logic [ADDR_W-1:0] ad [2] = '{7'h00, 7'h00};
  logic [DATA_W-1:0] wd [2] = '{16'h0000, 16'h0000};
  logic rdy [2];
  logic [DATA_W-1:0] rd [2];
  logic [DATA_W:0] q [2][$];
  logic [CFG0_CHAN_W-1:0] chan;
  logic eoc, busy, diff, samp;
  logic [ADDR_W-1:0] a;
  logic [DATA_W-1:0] d;
  int err_total = 0;
  int check_count = 0;
  int seed = 32'h3fefad34;
  always #10 clk_in = ~clk_in;
  ocm_sense_model i_sense (.level_in(level), .code_out(code));
  ocm_top i_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .osc_clk_sel_in(1'b1),
    .cfg_load_in(cfg_load_in), .cfg_init_data_in(init_v), .sample_code_in(code),
    .fab_en_in(en[0]), .fab_we_in(we[0]), .register_address_bus_in(ad[0]),
    .fab_wdata_in(wd[0]), .fab_rdy_out(rdy[0]), .fab_rdata_out(rd[0]),
    .scan_en_in(en[1]), .scan_we_in(we[1]), .scan_addr_in(ad[1]),
    .scan_wdata_in(wd[1]), .scan_rdy_out(rdy[1]), .scan_rdata_out(rd[1]),
    .chan_out(chan), .eoc_out(eoc), .busy_out(busy), .diff_mode_out(diff),
    .samp_mode_out(samp));
  task automatic chk(input logic [DATA_W-1:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // Called just after a rising edge; holds the request one cycle
  task automatic acc(input int p, input logic w, input logic [ADDR_W-1:0] ra,
                     input logic [DATA_W-1:0] rw, e, input logic c);
    int n = 0;
    q[p].push_back({c, e});
    en[p] <= 1'b1;
    we[p] <= w;
    ad[p] <= ra;
    wd[p] <= rw;
    @(posedge clk_in);
    en[p] <= 1'b0;
    do @(posedge clk_in); while (rdy[p] !== 1'b1 && ++n < 8);
    if (n >= 8) chk(16'h0001, 16'h0000);
  endtask : acc
  // ------------------------------------------------------------
  // Answer monitor
  // ------------------------------------------------------------
  always @(posedge clk_in)
    for (int p = 0; p < 2; p++)
      if (rdy[p] === 1'b1) begin
        if (q[p].size() == 0) chk(16'h0001, 16'h0000);
        else if (q[p][0][DATA_W]) chk(rd[p], q[p][0][DATA_W-1:0]);
        if (q[p].size() != 0) void'(q[p].pop_front());
      end
  initial begin
    #(20 * 20000);
    err_total++;
    tally_and_finish();
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    // Single-channel and averaging registers stay zero so the safe sequence keeps running
    for (int i = CTRL_BASE; i < REG_COUNT; i++)
      init_v[i] = (i == int'(CFG1_ADDR) || i == int'(AVG_ADDR)) ? 16'h0000 : 16'($random(seed));
    // Raw codes only; scaling to degrees or volts is left to the reader
    lv = '{FULL_SCALE, 10'h000, 10'($random(seed))};
    repeat (8) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    cfg_load_in <= 1'b1;
    @(posedge clk_in);
    cfg_load_in <= 1'b0;
    @(posedge clk_in);
    for (int i = CTRL_BASE; i < REG_COUNT; i++) acc(i % 2, 0, 7'(i), 0, init_v[i], 1);
    for (int i = 0; i < 6; i++) begin
      a = (i == 5) ? 7'h7f : 7'(int'(CTRL_BASE) + 3 + i);
      d = 16'($random(seed));
      acc(i % 2, 1, a, d, 0, 0);
      acc(1 - i % 2, 0, a, 0, d, 1);
    end
    cfg_load_in <= 1'b1;
    @(posedge clk_in);
    cfg_load_in <= 1'b0;
    @(posedge clk_in);
    acc(0, 0, 7'h7f, 0, init_v[127], 1);
    acc(0, 1, CFG0_ADDR, 16'h0500, 0, 0);
    repeat (2) @(posedge clk_in);
    chk({14'h0000, diff, samp}, 16'h0003);
    acc(1, 1, AVG_ADDR, 16'h0002, 0, 0);
    for (int k = 0; k < 3; k++) begin
      level <= lv[k];
      repeat (30 * CONV_CYC) @(posedge clk_in);
      for (int c = 0; c < 3; c++) acc(c % 2, 0, 7'(c), 0, {lv[k], 6'h00}, 1);
      acc(k % 2, 1, 7'(k), 16'hffff, 0, 0);
      acc(0, 0, 7'(k), 0, {lv[k], 6'h00}, 1);
    end
    // Single-channel mode on channel 1; results then come only from it
    acc(0, 1, CFG0_ADDR, 16'h0501, 0, 0);
    acc(1, 1, CFG1_ADDR, 16'h0001, 0, 0);
    repeat (12 * CONV_CYC) @(posedge clk_in);
    for (int n = 0; n < 8 * CONV_CYC && eoc !== 1'b1; n++) @(posedge clk_in);
    chk({15'h0000, eoc}, 16'h0001);
    chk({11'h000, chan}, 16'h0001);
    fork
      acc(0, 0, 7'h7f, 0, init_v[127], 1);
      acc(1, 0, CORE_ADDR, 0, {lv[2], 6'h00}, 1);
    join
    tally_and_finish();
  end
endmodule : tb_on_chip_monitor_adc_register_file
`default_nettype wire
